// file: logic/spba_regs.svh
// Purpose: register offsets, field positions, reset values and counts
//          of the secondary bus arbiter
// Assumes: included by the package and by the arbiter module
// Notes:   definitions only
`ifndef SPBA_REGS_SVH
`define SPBA_REGS_SVH

// ==========================================================
// agents
// ==========================================================
`define SPBA_NM 9
`define SPBA_NA 10
`define SPBA_BRIDGE 4'h9
`define SPBA_LOSLOT 4'hA
`define SPBA_RING_HI 11

// ==========================================================
// register offsets (byte addresses)
// ==========================================================
`define SPBA_OFF_PRIO 8'h40
`define SPBA_OFF_PARK 8'h48
`define SPBA_OFF_PREEMPT 8'h4C
`define SPBA_OFF_STATUS 8'h50

// ==========================================================
// field positions and reset values
// ==========================================================
`define SPBA_PARK_BIT 1
`define SPBA_PREEMPT_OFF_BIT 31
`define SPBA_TTP_MSB 2
`define SPBA_PRIO_RESET 10'h000
`define SPBA_TTP_RESET 3'h0
`define SPBA_BRIDGE_ONLY 10'h200
`define SPBA_ALL_HIGH 10'h3FF

// ==========================================================
// counts
// ==========================================================
`define SPBA_IDLE_TIMEOUT 5'h10
`define SPBA_PRE_MAX 7'h7F

`endif

// file: logic/spba_pkg.sv
// Purpose: types of the secondary bus arbiter
// Assumes: spba_regs.svh holds every number
// Notes:   the whole state of the arbiter is one packed struct
`include "spba_regs.svh"

package spba_pkg;

  // ==========================================================
  // state of the arbiter
  // ==========================================================
  typedef struct packed {
    logic [9:0] prio;        // priority group bits, 1 = high
    logic park_force;        // park at the bridge
    logic preempt_off;       // 1 disables preemption
    logic [2:0] ttp;         // time-to-preempt code
    logic ext_mode;          // strap seen high
    logic frame_d;           // frame one cycle ago
    logic g_valid;           // a grant is asserted
    logic [3:0] g_idx;       // owner of that grant
    logic [3:0] hi_ptr;      // top of the high ring
    logic [3:0] lo_ptr;      // top of the low ring
    logic [9:0] to_mask;     // masters that timed out
    logic [4:0] to_cnt;      // idle granted cycles
    logic [6:0] pre_cnt;     // waiting cycles of next master
    logic [8:0] gnt_n;       // grant pins
    logic bridge_gnt;        // bridge holds the bus
    logic sec_start;         // bridge starts secondary cycle
    logic sec_ad_oe_n;       // secondary ad/cbe park enable
    logic sec_par_oe_n;      // secondary parity park enable
    logic p_req_n;           // primary request pin
    logic p_start;           // bridge starts primary cycle
    logic p_ad_oe_n;         // primary ad/cbe park enable
    logic primary_parity_oe_n;        // primary parity park enable
    logic [31:0] rdata;      // read data
  } spba_state_t;

  // reset: parked at the bridge, everything else quiet
  localparam spba_state_t SPBA_RST = '{
    prio: `SPBA_PRIO_RESET, park_force: 1'b0, preempt_off: 1'b0,
    ttp: `SPBA_TTP_RESET, ext_mode: 1'b0, frame_d: 1'b1,
    g_valid: 1'b1, g_idx: `SPBA_BRIDGE, hi_ptr: `SPBA_BRIDGE,
    lo_ptr: 4'h0, to_mask: 10'h000, to_cnt: 5'h00, pre_cnt: 7'h00,
    gnt_n: 9'h1FF, bridge_gnt: 1'b1, sec_start: 1'b0,
    sec_ad_oe_n: 1'b1, sec_par_oe_n: 1'b1, p_req_n: 1'b1,
    p_start: 1'b0, p_ad_oe_n: 1'b1, primary_parity_oe_n: 1'b1,
    rdata: 32'h0000_0000};

endpackage : spba_pkg

// file: logic/spba_arbiter.sv
// Purpose: secondary bus arbiter, external arbiter mode and parking
//          on both buses of a bus bridge
// Assumes: all inputs synchronous to ref_clk; strap is static
// Notes:   register port answers reads one cycle later, never waits
`timescale 1ns/1ps
`include "spba_regs.svh"

// Behaviour
// - strap low: nine request/grant pairs arbitrated
// - low group is one slot in high ring
// - one priority bit per master at 40h
// - one group: bridge high, every other turn
// - re-evaluate at frame start, grant highest request
// - higher request takes grant next clock
// - previous initiator drops to lowest in group
// - withdraw grant after 16 idle unused cycles
// - idle bus: one-clock gap between grants
// - busy bus: grants may switch same clock
// - bit 31 at 4Ch disables preemption
// - preempt time 0 to 64 clocks, reset 0
// - preempt owner after next waits preempt time
// - strap high: pair 0 is bridge request/grant
// - external grant seen: start one cycle later
// - external grant without request: park the bus
// - external mode: unused grants driven high
// - park ad/cbe first, parity one cycle later
// - primary park only granted, idle, not requesting
// - parked with pending work: start next clock
// - park at last master, at bridge after reset
// - bit 1 at 48h forces park at bridge
module spba_arbiter
  import spba_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // secondary bus
  input wire logic arbiter_select_strap,
  input wire logic [8:0] req_n,
  output logic [8:0] gnt_n,
  input wire logic s_frame_n,
  input wire logic secondary_initiator_ready_n,
  input wire logic bridge_req,
  output logic bridge_gnt,
  output logic sec_start,
  output logic sec_ad_oe_n,
  output logic sec_par_oe_n,
  // primary bus
  input wire logic p_pending,
  output logic p_req_n,
  input wire logic p_gnt_n,
  input wire logic p_frame_n,
  input wire logic p_irdy_n,
  output logic p_start,
  output logic p_ad_oe_n,
  output logic primary_parity_oe_n
);

  // ==========================================================
  // helpers
  // ==========================================================
  // winner search: low ring first, then the high ring, whose
  // order is masters 0..8, the low group slot, then the bridge
  function automatic logic [4:0] spba_pick(input logic [9:0] rq,
                                           input logic [9:0] hs,
                                           input logic [3:0] hp,
                                           input logic [3:0] lp);
    logic [9:0] lo_rq;
    logic [4:0] hw;
    logic [4:0] lw;
    int p;
    int q;  // agent at a high ring position
    int hr; // ring position of the high pointer
    lo_rq = rq & ~hs;
    hw = 5'h00;
    lw = 5'h00;
    p = 0;
    q = 0;
    hr = (hp == `SPBA_BRIDGE) ? `SPBA_NA :
         ((hp == `SPBA_LOSLOT) ? `SPBA_NM : int'(hp));
    for (int k = 0; k < `SPBA_NA; k++) begin
      p = (int'(lp) + k) % `SPBA_NA;
      if (!lw[4] && lo_rq[p]) begin
        lw = {1'b1, 4'(p)};
      end
    end
    for (int k = 0; k < `SPBA_RING_HI; k++) begin
      p = (hr + k) % `SPBA_RING_HI;
      q = (p == `SPBA_NA) ? `SPBA_NM : p;
      if (!hw[4]) begin
        if (p == `SPBA_NM) begin
          hw = lw; // low slot takes the low winner
        end else if (rq[q] && hs[q]) begin
          hw = {1'b1, 4'(q)};
        end
      end
    end
    return hw;
  endfunction

  // time-to-preempt code to clocks: 0,1,2,4,...,64
  function automatic logic [6:0] spba_ttp(input logic [2:0] code);
    logic [6:0] v;
    v = 7'h00;
    if (code != 3'h0) begin
      v = 7'h01 << (code - 3'h1);
    end
    return v;
  endfunction

  // ==========================================================
  // state
  // ==========================================================
  spba_state_t st_reg;   // all flip-flops
  spba_state_t st_next;  // their next value
  logic s_idle;          // secondary bus idle
  logic p_idle;          // primary bus idle
  logic fstart;          // frame just asserted
  logic [9:0] rq_raw;    // requests, bridge on top
  logic [9:0] rq;        // requests less timed-out masters
  logic [9:0] hs;        // effective high group
  logic [4:0] pk;        // search result
  logic want_v;          // somebody should hold the grant
  logic [3:0] want;      // who
  logic owner_req;       // external owner is requesting
  logic my_gnt;          // bridge granted on secondary
  logic s_park;          // bridge parks secondary
  logic p_park;          // bridge parks primary

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    st_next = st_reg;
    // strap is static; sampled each clock, never under reset
    st_next.ext_mode = arbiter_select_strap;
    st_next.frame_d = s_frame_n;
    s_idle = s_frame_n & secondary_initiator_ready_n;
    p_idle = p_frame_n & p_irdy_n;
    fstart = st_reg.frame_d & ~s_frame_n;
    rq_raw = {bridge_req, ~req_n};
    rq = rq_raw & ~st_reg.to_mask;
    // a single group falls back to bridge against everyone
    if (st_reg.prio == 10'h000 || st_reg.prio == `SPBA_ALL_HIGH) begin
      hs = `SPBA_BRIDGE_ONLY;
    end else begin
      hs = st_reg.prio;
    end
    pk = spba_pick(rq, hs, st_reg.hi_ptr, st_reg.lo_ptr);
    want_v = pk[4];
    want = pk[3:0];
    // forced park: with nobody asking the bridge takes it
    if (!want_v && st_reg.park_force) begin
      want_v = 1'b1;
      want = `SPBA_BRIDGE;
    end
    owner_req = st_reg.g_valid && rq_raw[st_reg.g_idx]
                && st_reg.g_idx != `SPBA_BRIDGE;

    // ---------- register port ----------
    if (reg_wr) begin
      unique case (reg_addr)
        `SPBA_OFF_PRIO: st_next.prio = reg_wdata[9:0];
        `SPBA_OFF_PARK:
          st_next.park_force = reg_wdata[`SPBA_PARK_BIT];
        `SPBA_OFF_PREEMPT: begin
          st_next.preempt_off = reg_wdata[`SPBA_PREEMPT_OFF_BIT];
          st_next.ttp = reg_wdata[`SPBA_TTP_MSB:0];
        end
        default: ; // unmapped writes are dropped
      endcase
    end
    st_next.rdata = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `SPBA_OFF_PRIO: st_next.rdata = {22'h0, st_reg.prio};
        `SPBA_OFF_PARK:
          st_next.rdata = {30'h0, st_reg.park_force, 1'b0};
        `SPBA_OFF_PREEMPT:
          st_next.rdata = {st_reg.preempt_off, 28'h0, st_reg.ttp};
        `SPBA_OFF_STATUS:
          st_next.rdata = {12'h0, st_reg.lo_ptr, st_reg.hi_ptr,
                           st_reg.ext_mode, st_reg.g_valid,
                           6'h00, st_reg.g_idx};
        default: st_next.rdata = 32'h0000_0000; // unmapped reads 0
      endcase
    end

    // ---------- internal arbiter ----------
    if (!st_reg.ext_mode) begin
      // rotate at each frame start around the initiator
      if (fstart) begin
        st_next.to_mask = 10'h000;
        if (st_reg.g_valid) begin
          if (hs[st_reg.g_idx]) begin
            // after master 8 comes the low slot, after the bridge 0
            if (st_reg.g_idx == `SPBA_BRIDGE) begin
              st_next.hi_ptr = 4'h0;
            end else if (st_reg.g_idx == 4'h8) begin
              st_next.hi_ptr = `SPBA_LOSLOT;
            end else begin
              st_next.hi_ptr = st_reg.g_idx + 4'h1;
            end
          end else begin
            // low slot used: bridge is next in the high ring
            st_next.hi_ptr = `SPBA_BRIDGE;
            st_next.lo_ptr = (st_reg.g_idx == `SPBA_BRIDGE) ?
                             4'h0 : st_reg.g_idx + 4'h1;
          end
        end
      end
      // idle granted cycles without a frame
      if (owner_req && s_idle) begin
        st_next.to_cnt = st_reg.to_cnt + 5'h01;
      end else begin
        st_next.to_cnt = 5'h00;
      end
      if (owner_req && s_idle
          && st_reg.to_cnt == `SPBA_IDLE_TIMEOUT - 5'h01) begin
        // silent master loses the grant until next frame
        st_next.g_valid = 1'b0;
        st_next.to_mask[st_reg.g_idx] = 1'b1;
        st_next.to_cnt = 5'h00;
        st_next.pre_cnt = 7'h00;
      end else if (want_v
                   && (!st_reg.g_valid || want != st_reg.g_idx)) begin
        if (s_idle) begin
          // idle bus: drop first, grant on the next clock
          st_next.pre_cnt = 7'h00;
          if (st_reg.g_valid) begin
            st_next.g_valid = 1'b0;
          end else begin
            st_next.g_valid = 1'b1;
            st_next.g_idx = want;
          end
        end else if (!st_reg.g_valid) begin
          // busy with no grant out: nothing to collide with
          st_next.g_valid = 1'b1;
          st_next.g_idx = want;
          st_next.pre_cnt = 7'h00;
        end else if (!st_reg.preempt_off
                     && st_reg.pre_cnt >= spba_ttp(st_reg.ttp)) begin
          // busy bus: swap in one clock, frame keeps it owned
          st_next.g_idx = want;
          st_next.pre_cnt = 7'h00;
        end else if (st_reg.pre_cnt != `SPBA_PRE_MAX) begin
          st_next.pre_cnt = st_reg.pre_cnt + 7'h01;
        end
      end else begin
        // nobody new: grant stays where it is, the park
        st_next.pre_cnt = 7'h00;
      end
      for (int i = 0; i < `SPBA_NM; i++) begin
        st_next.gnt_n[i] = !(st_next.g_valid
                             && st_next.g_idx == 4'(i));
      end
      st_next.bridge_gnt = st_next.g_valid
                           && st_next.g_idx == `SPBA_BRIDGE;
      st_next.sec_start = st_reg.bridge_gnt & bridge_req & s_idle;
      my_gnt = st_reg.bridge_gnt;
    end else begin
      // ---------- external arbiter mode ----------
      st_next.g_valid = 1'b0;
      st_next.to_cnt = 5'h00;
      st_next.pre_cnt = 7'h00;
      st_next.gnt_n = {8'hFF, ~bridge_req};
      my_gnt = ~req_n[0];
      st_next.bridge_gnt = my_gnt;
      // grant seen while requesting: frame goes out next cycle
      st_next.sec_start = my_gnt & ~st_reg.gnt_n[0];
    end

    // ---------- secondary parking ----------
    // ad/cbe first, parity one clock behind them
    s_park = my_gnt & ~bridge_req & s_idle;
    st_next.sec_ad_oe_n = ~s_park;
    st_next.sec_par_oe_n = ~(s_park & ~st_reg.sec_ad_oe_n);

    // ---------- primary request and parking ----------
    st_next.p_req_n = ~p_pending;
    p_park = ~p_gnt_n & st_reg.p_req_n & p_idle;
    st_next.p_ad_oe_n = ~p_park;
    st_next.primary_parity_oe_n = ~(p_park & ~st_reg.p_ad_oe_n);
    // grant held while requesting: start on the next clock
    st_next.p_start = ~p_gnt_n & ~st_reg.p_req_n & p_idle;
  end

  // ==========================================================
  // registers
  // ==========================================================
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_reg <= SPBA_RST; // parked at bridge
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs, all straight from flip-flops
  // ==========================================================
  assign reg_rdata = st_reg.rdata;
  assign gnt_n = st_reg.gnt_n;
  assign bridge_gnt = st_reg.bridge_gnt;
  assign sec_start = st_reg.sec_start;
  assign sec_ad_oe_n = st_reg.sec_ad_oe_n;
  assign sec_par_oe_n = st_reg.sec_par_oe_n;
  assign p_req_n = st_reg.p_req_n;
  assign p_start = st_reg.p_start;
  assign p_ad_oe_n = st_reg.p_ad_oe_n;
  assign primary_parity_oe_n = st_reg.primary_parity_oe_n;

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // at most one grant in internal mode
  property p_onehot;
    !st_reg.ext_mode |-> $onehot0(~gnt_n);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("more than one grant asserted");

  // unused grants high in external mode
  property p_ext_unused;
    st_reg.ext_mode |=> gnt_n[8:1] == 8'hFF;
  endproperty
  a_ext_unused: assert property (p_ext_unused)
    else $error("unused grant driven low");

  // no grant swap decided on an idle bus
  property p_idle_gap;
    (s_idle && !st_reg.ext_mode && !st_next.ext_mode
     && gnt_n != 9'h1FF)
    |=> (gnt_n == 9'h1FF || gnt_n == $past(gnt_n));
  endproperty
  a_idle_gap: assert property (p_idle_gap)
    else $error("grants swapped on idle bus");

  // sixteenth idle granted cycle removes the grant
  property p_timeout;
    (!st_reg.ext_mode && owner_req && s_idle
     && st_reg.to_cnt == 5'h0F) |=> gnt_n == 9'h1FF;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("grant kept past idle timeout");

  // parity only after ad/cbe were already driven
  property p_park_par;
    !sec_par_oe_n |-> $past(!sec_ad_oe_n);
  endproperty
  a_park_par: assert property (p_park_par)
    else $error("parity parked before ad");

  // primary lines released the clock after the grant drops
  property p_p_tristate;
    p_gnt_n |=> p_ad_oe_n && primary_parity_oe_n;
  endproperty
  a_p_tristate: assert property (p_p_tristate)
    else $error("primary still parked without grant");

  // external grant while requesting starts a cycle next clock
  property p_ext_start;
    (st_reg.ext_mode && !req_n[0] && !gnt_n[0]) |=> sec_start;
  endproperty
  a_ext_start: assert property (p_ext_start)
    else $error("no start after external grant");

  // primary start only after a held grant and request
  property p_p_start;
    p_start |-> $past(!p_gnt_n) && $past(!p_req_n);
  endproperty
  a_p_start: assert property (p_p_start)
    else $error("primary start without grant");

endmodule // spba_arbiter

// file: tb/spba_bus_model.sv
// Purpose: far side of the arbiter: secondary masters, the outer
//          secondary arbiter and the primary arbiter
// Assumes: the bench picks requesters through want and park inputs
// Notes:   a muted master requests but never starts a cycle
`timescale 1ns/1ps
// ==========================================================
// bus model
// ==========================================================
module spba_bus_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ext_mode,
  input wire logic [8:0] want,
  input wire logic [8:0] mute,
  input wire logic long_tx,
  input wire logic park_s,
  input wire logic p_park,
  input wire logic [8:0] gnt_n,
  input wire logic p_req_n,
  output logic [8:0] req_n,
  output logic s_frame_n,
  output logic s_irdy_n,
  output logic started,
  output logic [3:0] last_init,
  output logic p_gnt_n,
  output logic p_frame_n,
  output logic p_irdy_n
);
  logic [5:0] left; // frame cycles still to run
  logic ext_gnt; // outer arbiter grant to the bridge

  // unused requests held high by the board in outer mode
  assign req_n = ext_mode ? {8'hFF, ~ext_gnt} : ~want;
  // primary stays idle: only the bridge would start there
  assign p_frame_n = 1'h1;
  assign p_irdy_n = 1'h1;

  // masters start only on an idle bus while granted
  always_ff @(posedge ref_clk) begin
    started <= 1'h0;
    if (!rst_n) begin
      s_frame_n <= 1'h1;
      s_irdy_n <= 1'h1;
      left <= 6'h00;
      ext_gnt <= 1'h0;
      p_gnt_n <= 1'h1;
      last_init <= 4'hF;
    end else begin
      ext_gnt <= ext_mode & (~gnt_n[0] | park_s);
      p_gnt_n <= p_req_n & ~p_park;
      if (left > 6'h01) begin
        left <= left - 6'h01;
      end else if (left == 6'h01) begin
        // last data phase: frame released, ready still low
        left <= 6'h00;
        s_frame_n <= 1'h1;
      end else if (!s_irdy_n) begin
        s_irdy_n <= 1'h1;
      end else if (!ext_mode && s_frame_n) begin
        for (int k = 0; k < 9; k++) begin
          if (!gnt_n[k] && want[k] && !mute[k]) begin
            s_frame_n <= 1'h0;
            s_irdy_n <= 1'h0;
            left <= long_tx ? 6'h28 : 6'h01;
            started <= 1'h1;
            last_init <= k[3:0];
          end
        end
      end
    end
  end
endmodule // spba_bus_model

// file: tb/spba_arbiter_tb.sv
// Purpose: self-checking bench of the secondary bus arbiter
// Assumes: bus model plays masters and both outer arbiters
// Notes:   reads compare the cycle after the strobe, then zero
`timescale 1ns/1ps
module spba_arbiter_tb;
  import spba_pkg::*;
  // ==========================================================
  // signals
  // ==========================================================
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'h0, reg_rd = 1'h0, strap = 1'h0, bridge_req = 1'h0;
  logic p_pending = 1'h0, long_tx = 1'h0, park_s = 1'h0, p_park = 1'h0;
  logic [8:0] want = 9'h000, mute = 9'h000, req_n, gnt_n;
  logic [31:0] reg_rdata;
  logic s_frame_n, s_irdy_n, bridge_gnt, sec_start, sec_ad_oe_n;
  logic sec_par_oe_n, p_req_n, p_gnt_n, p_frame_n, p_irdy_n, p_start;
  logic p_ad_oe_n, primary_parity_oe_n, started;
  logic [3:0] last_init;
  logic [3:0] seq[$]; // initiators in start order
  logic [3:0] rot[12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h0, 4'h1, 4'h2, 4'h4,
                          4'h0, 4'h1, 4'h2, 4'h5};
  int bad_count = 0;
  int samples_checked = 0;
  int n;

  spba_arbiter spba_arbiter_i (.ref_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .arbiter_select_strap(strap), .req_n,
    .gnt_n, .s_frame_n, .secondary_initiator_ready_n(s_irdy_n), .bridge_req,
    .bridge_gnt, .sec_start, .sec_ad_oe_n, .sec_par_oe_n, .p_pending,
    .p_req_n, .p_gnt_n, .p_frame_n, .p_irdy_n, .p_start, .p_ad_oe_n,
    .primary_parity_oe_n);
  spba_bus_model spba_bus_model_i (.ref_clk, .rst_n, .ext_mode(strap),
    .want, .mute, .long_tx, .park_s, .p_park, .gnt_n, .p_req_n, .req_n,
    .s_frame_n, .s_irdy_n, .started, .last_init, .p_gnt_n, .p_frame_n,
    .p_irdy_n);

  // ==========================================================
  // clock, start monitor, watchdog
  // ==========================================================
  initial forever #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (started === 1'h1) seq.push_back(last_init);
  // about 400 cycles expected; a hang ends the run here
  initial begin
    repeat (6000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end

  // ==========================================================
  // tasks
  // ==========================================================
  task automatic chk(input string what, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chkb(input string what, input logic e, g);
    chk(what, {31'h0, e}, {31'h0, g});
  endtask
  task automatic stop_test();
    if (bad_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // settle after k edges so registered outputs have landed
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic do_reset(input logic s);
    @(posedge ref_clk);
    rst_n <= 1'h0;
    strap <= s;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'h1;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  // read data stands one cycle only, zero after
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 chk("read data", e, reg_rdata & m);
    cyc(1);
    chk("read idle", 32'h0000_0000, reg_rdata);
  endtask
  // address lines park first, parity one cycle later
  task automatic park_seq(input logic prim);
    int k;
    k = 0;
    while ((prim ? p_ad_oe_n : sec_ad_oe_n) !== 1'h0 && k < 8) begin
      cyc(1);
      k++;
    end
    chkb("ad park", 1'h0, prim ? p_ad_oe_n : sec_ad_oe_n);
    chkb("par late", 1'h1, prim ? primary_parity_oe_n : sec_par_oe_n);
    cyc(1);
    chkb("par park", 1'h0, prim ? primary_parity_oe_n : sec_par_oe_n);
  endtask
  // master 1 runs a long cycle, master 2 waits; count owner hold
  task automatic preempt(input logic [31:0] cfg, output int k);
    wr(`SPBA_OFF_PREEMPT, cfg);
    @(posedge ref_clk);
    long_tx <= 1'h1;
    want <= 9'h002;
    k = 0;
    while (s_frame_n !== 1'h0 && k < 20) begin
      cyc(1);
      k++;
    end
    @(posedge ref_clk);
    want <= 9'h006;
    k = 0;
    cyc(1);
    while (gnt_n[1] === 1'h0 && k < 30) begin
      cyc(1);
      k++;
    end
    @(posedge ref_clk);
    want <= 9'h000;
    long_tx <= 1'h0;
    cyc(50);
  endtask

  // ==========================================================
  // tests
  // ==========================================================
  initial begin
    do_reset(1'h0);
    chk("grants", 32'h0000_01FF, {23'h0, gnt_n});
    chkb("bridge parked", 1'h1, bridge_gnt);
    rchk(`SPBA_OFF_PRIO, 32'h0000_03FF, 32'h0000_0000);
    rchk(`SPBA_OFF_PARK, 32'h0000_0002, 32'h0000_0000);
    rchk(`SPBA_OFF_PREEMPT, 32'h8000_0007, 32'h0000_0000);
    rchk(8'h44, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(`SPBA_OFF_PRIO, 32'h0000_03FF);
    rchk(`SPBA_OFF_PRIO, 32'h0000_03FF, 32'h0000_03FF);
    wr(`SPBA_OFF_PRIO, 32'h0000_0000);
    // every time-to-preempt code with preemption off, then preemption on
    for (int c = 0; c < 8; c++) begin
      wr(`SPBA_OFF_PREEMPT, 32'h8000_0000 | c);
      rchk(`SPBA_OFF_PREEMPT, 32'h8000_0007, 32'h8000_0000 | c);
    end
    wr(`SPBA_OFF_PREEMPT, 32'h0000_0000);
    // idle bus: bridge grant drops, one empty cycle, then master 3
    @(posedge ref_clk);
    want <= 9'h008;
    cyc(1);
    chk("gap grants", 32'h0000_01FF, {23'h0, gnt_n});
    chkb("gap bridge", 1'h0, bridge_gnt);
    cyc(1);
    chk("new grant", 32'h0000_01F7, {23'h0, gnt_n});
    @(posedge ref_clk);
    want <= 9'h000;
    cyc(10);
    chk("parked last", 32'h0000_01F7, {23'h0, gnt_n});
    // silent master loses its grant after sixteen idle cycles
    @(posedge ref_clk);
    mute <= 9'h020;
    want <= 9'h020;
    n = 0;
    while (gnt_n[5] !== 1'h0 && n < 8) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (gnt_n[5] === 1'h0 && n < 40) begin
      cyc(1);
      n++;
    end
    chkb("idle timeout", 1'h1, n >= 16 && n <= 17);
    @(posedge ref_clk);
    want <= 9'h000;
    mute <= 9'h000;
    // bridge and masters 0..2 high, the rest share the low slot
    do_reset(1'h0);
    wr(`SPBA_OFF_PRIO, 32'h0000_0207);
    seq.delete();
    @(posedge ref_clk);
    want <= 9'h1FF;
    n = 0;
    while (seq.size() < 12 && n < 400) begin
      cyc(1);
      n++;
    end
    @(posedge ref_clk);
    want <= 9'h000;
    cyc(8);
    for (int i = 0; i < 12; i++) begin
      chk("initiator", {28'h0, rot[i]}, {28'h0, seq[i]});
    end
    // preemption after four clocks, then none with preemption off
    do_reset(1'h0);
    preempt(32'h0000_0003, n);
    chkb("preempt time", 1'h1, n >= 3 && n <= 6);
    preempt(32'h8000_0000, n);
    chk("no preempt", 32'h0000_001E, n);
    // forced park at the bridge with nobody requesting
    wr(`SPBA_OFF_PARK, 32'h0000_0002);
    cyc(4);
    chkb("forced park", 1'h1, bridge_gnt);
    chk("forced grants", 32'h0000_01FF, {23'h0, gnt_n});
    rchk(`SPBA_OFF_PARK, 32'h0000_0002, 32'h0000_0002);
    // primary: request, grant, start; then park and release
    @(posedge ref_clk);
    p_pending <= 1'h1;
    n = 0;
    while (p_start !== 1'h1 && n < 8) begin
      cyc(1);
      n++;
    end
    chkb("primary start", 1'h1, p_start);
    chkb("no park busy", 1'h1, p_ad_oe_n);
    chkb("primary request", 1'h0, p_req_n);
    @(posedge ref_clk);
    p_pending <= 1'h0;
    p_park <= 1'h1;
    park_seq(1'h1);
    @(posedge ref_clk);
    p_park <= 1'h0;
    cyc(1);
    cyc(1);
    chkb("primary release", 1'h1, p_ad_oe_n & primary_parity_oe_n);
    // outer arbiter mode: pair 0 becomes request and grant
    do_reset(1'h1);
    cyc(2);
    chk("outer idle", 32'h0000_01FF, {23'h0, gnt_n});
    rchk(`SPBA_OFF_STATUS, 32'h0000_0C00, 32'h0000_0800);
    @(posedge ref_clk);
    bridge_req <= 1'h1;
    cyc(2);
    chk("outer request", 32'h0000_01FE, {23'h0, gnt_n});
    chkb("start early", 1'h0, sec_start);
    cyc(1);
    chkb("start", 1'h1, sec_start);
    @(posedge ref_clk);
    bridge_req <= 1'h0;
    park_s <= 1'h1;
    park_seq(1'h0);
    stop_test();
  end
endmodule // spba_arbiter_tb
